/* File: design/bus_cmd_cfg.svh */
// Constants for the bus cycle command controller
`ifndef BUS_CMD_CFG_SVH
`define BUS_CMD_CFG_SVH

// Status pair {bit1_n, bit0_n} codes as seen on the pins (low = asserted)
`define BCC_STATUS_BOTH 2'h0
`define BCC_STATUS_READ 2'h1
`define BCC_STATUS_WRITE 2'h2
`define BCC_STATUS_IDLE 2'h3

// Level of the memory/IO select for memory space
`define BCC_SPACE_MEM 1'h1

// Level of the mode strap that selects system-bus-compatible timing
`define BCC_MODE_COMPAT 1'h1

// Reset values of the outputs
`define BCC_CMD_N_RST 1'h1
`define BCC_DATA_EN_RST 1'h0
`define BCC_DATA_DIR_RST 1'h0
`define BCC_ALE_RST 1'h0
`define BCC_MODE_RST 1'h0

// Extra falling edges a command waits for in compatible mode
`define BCC_COMPAT_DELAY_CYCLES 1

`endif

/* File: design/bus_cmd_ctrl.sv */
// Bus cycle command controller: status decode, command strobes, data control
// Overview of operation
// - Sample inputs, change outputs on falling edge only
// - Status inputs are active low
// - Either status input low starts a cycle
// - Cycle type from status plus space select
// - Separate memory and I/O command strobes
// - Separate data enable and direction outputs
// - Strap selects compatible or high-speed timing
// - Static logic, supports a low power mode
// - Select low is I/O, high is memory
// - I/O: acknowledge, read, write, idle
// - Memory: halt, read, write, idle
`timescale 1ns/1ps
`default_nettype none
`include "bus_cmd_cfg.svh"

module bus_cmd_ctrl
    import bus_cmd_pkg::*;
(
    input wire logic CLK_IN, // Controller clock, 20 MHz
    input wire logic SRST_IN, // Synchronous reset, active high
    input wire logic CYCLE_STATUS_BIT0_N_IN, // Cycle status bit 0, active low
    input wire logic CYCLE_STATUS_BIT1_N_IN, // Cycle status bit 1, active low
    input wire logic MEM_IO_SEL_IN, // High memory space, low I/O space
    input wire logic READY_N_IN, // Ends the command phase when low
    input wire logic MODE_STRAP_IN, // High selects compatible timing
    input wire logic LOW_POWER_IN, // High holds off new cycles
    output logic ADDR_LATCH_OUT, // One-cycle pulse at cycle start
    output logic MEM_RD_N_OUT, // Memory read command, active low
    output logic MEM_WR_N_OUT, // Memory write command, active low
    output logic IO_RD_N_OUT, // I/O read command, active low
    output logic IO_WR_N_OUT, // I/O write command, active low
    output logic INTA_N_OUT, // Interrupt acknowledge, active low
    output logic DATA_EN_OUT, // Data transceiver enable, active high
    output logic DATA_DIR_OUT // High transmit (write), low receive
);

    // Registered state
    ctl_state_type state; // Sequencer state
    cycle_kind_type kind; // Kind of the cycle in progress
    logic compat_mode; // Strap value caught at reset
    logic ale; // Address latch pulse
    logic mem_rd_n; // Memory read strobe
    logic mem_wr_n; // Memory write strobe
    logic io_rd_n; // I/O read strobe
    logic io_wr_n; // I/O write strobe
    logic inta_n; // Acknowledge strobe
    logic data_en; // Transceiver enable
    logic data_dir; // Transceiver direction

    // Decode wires
    wire [1:0] status_n; // Status pair as on the pins
    cycle_kind_type decoded_kind; // Kind decoded this edge
    wire status_active; // Either status bit asserted
    wire cycle_start; // A new cycle begins this edge
    wire has_command; // Decoded kind drives a strobe
    cycle_kind_type next_kind; // Kind held after this edge
    ctl_state_type next_state; // State after this edge
    wire next_in_cmd; // Command phase after this edge
    wire next_in_cycle; // Any active phase after this edge
    wire next_is_write; // Cycle after this edge writes
    wire next_mem_rd_n;
    wire next_mem_wr_n;
    wire next_io_rd_n;
    wire next_io_wr_n;
    wire next_inta_n;
    wire next_data_en;
    wire next_data_dir;

    // Status pair, low means asserted
    assign status_n = {CYCLE_STATUS_BIT1_N_IN, CYCLE_STATUS_BIT0_N_IN};
    assign status_active = (status_n != `BCC_STATUS_IDLE);

    // Kind decode from status and space select
    cycle_decoder u_decoder (
        .status_n_in(status_n),
        .space_in(MEM_IO_SEL_IN),
        .kind_out(decoded_kind)
    );

    // New cycle only from idle, and never in low power mode
    assign cycle_start = (state == ST_IDLE) && status_active && !LOW_POWER_IN;
    // Halt and idle codes give no strobe
    assign has_command = (decoded_kind != CYC_HALT) && (decoded_kind != CYC_IDLE);

    // Latch kind at cycle start, hold it otherwise
    assign next_kind = cycle_start ? decoded_kind : kind;

    // Sequencer: compatible mode inserts one delay state before the strobe
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (cycle_start && has_command) begin
                    // One processor state is two edges here, so the delay stays short
                    next_state = compat_mode ? ST_DELAY : ST_CMD;
                end
            end
            ST_DELAY: begin
                next_state = ST_CMD;
            end
            ST_CMD: begin
                if (!READY_N_IN) begin // Ready ends the command
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // Strobe selection, memory and I/O never share one
    assign next_in_cmd = (next_state == ST_CMD);
    assign next_in_cycle = (next_state != ST_IDLE);
    assign next_is_write = (next_kind == CYC_MWR) || (next_kind == CYC_IOWR);
    assign next_mem_rd_n = !(next_in_cmd && next_kind == CYC_MRD);
    assign next_mem_wr_n = !(next_in_cmd && next_kind == CYC_MWR);
    assign next_io_rd_n = !(next_in_cmd && next_kind == CYC_IORD);
    assign next_io_wr_n = !(next_in_cmd && next_kind == CYC_IOWR);
    assign next_inta_n = !(next_in_cmd && next_kind == CYC_INTA);

    // Data path: writes enable for the whole cycle, reads only with the strobe
    assign next_data_en = next_is_write ? next_in_cycle : next_in_cmd;
    assign next_data_dir = next_in_cycle && next_is_write;

    // Strap caught while reset is held; static afterwards
    always_ff @(negedge CLK_IN) begin
        if (SRST_IN) begin
            compat_mode <= (MODE_STRAP_IN == `BCC_MODE_COMPAT);
        end
    end

    // State and kind; plain flip-flops hold when the clock stops
    always_ff @(negedge CLK_IN) begin
        if (SRST_IN) begin
            state <= ST_IDLE;
            kind <= CYC_IDLE;
        end else begin
            state <= next_state;
            kind <= next_kind;
        end
    end

    // Output flip-flops, all on the falling edge
    always_ff @(negedge CLK_IN) begin
        if (SRST_IN) begin
            ale <= `BCC_ALE_RST;
            mem_rd_n <= `BCC_CMD_N_RST;
            mem_wr_n <= `BCC_CMD_N_RST;
            io_rd_n <= `BCC_CMD_N_RST;
            io_wr_n <= `BCC_CMD_N_RST;
            inta_n <= `BCC_CMD_N_RST;
            data_en <= `BCC_DATA_EN_RST;
            data_dir <= `BCC_DATA_DIR_RST;
        end else begin
            ale <= cycle_start;
            mem_rd_n <= next_mem_rd_n;
            mem_wr_n <= next_mem_wr_n;
            io_rd_n <= next_io_rd_n;
            io_wr_n <= next_io_wr_n;
            inta_n <= next_inta_n;
            data_en <= next_data_en;
            data_dir <= next_data_dir;
        end
    end

    // Port drive
    assign ADDR_LATCH_OUT = ale;
    assign MEM_RD_N_OUT = mem_rd_n;
    assign MEM_WR_N_OUT = mem_wr_n;
    assign IO_RD_N_OUT = io_rd_n;
    assign IO_WR_N_OUT = io_wr_n;
    assign INTA_N_OUT = inta_n;
    assign DATA_EN_OUT = data_en;
    assign DATA_DIR_OUT = data_dir;

    // Checks on the falling edge except the last, which is clocked on both edges; quiet during reset

    ale_on_start_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        cycle_start |=> ale ##1 !ale)
        else $error("latch pulse missing or too long after cycle start");

    idle_no_start_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (state == ST_IDLE && status_n == `BCC_STATUS_IDLE) |=> !ale && state == ST_IDLE)
        else $error("cycle started with both status bits high");

    space_split_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (!mem_rd_n || !mem_wr_n) |-> (io_rd_n && io_wr_n && inta_n))
        else $error("memory and I/O strobes active together");

    io_read_fast_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (cycle_start && !compat_mode && !MEM_IO_SEL_IN && status_n == `BCC_STATUS_READ)
        |=> !io_rd_n && mem_rd_n && !data_dir)
        else $error("I/O read strobe not on first edge in high-speed mode");

    mem_write_compat_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (cycle_start && compat_mode && decoded_kind == CYC_MWR)
        |=> (mem_wr_n && data_en && data_dir) ##1 !mem_wr_n)
        else $error("compatible memory write not delayed by one edge");

    halt_no_cmd_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (cycle_start && decoded_kind == CYC_HALT)
        |=> state == ST_IDLE && mem_rd_n && mem_wr_n && !data_en)
        else $error("halt cycle produced a command");

    write_dir_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (!mem_wr_n || !io_wr_n) |-> (data_dir && data_en))
        else $error("write strobe without transmit direction");

    ready_end_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (state == ST_CMD && !READY_N_IN)
        |=> mem_rd_n && mem_wr_n && io_rd_n && io_wr_n && inta_n && !data_en)
        else $error("strobes not released after ready");

    low_power_hold_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (state == ST_IDLE && LOW_POWER_IN) |=> (state == ST_IDLE && !ale))
        else $error("cycle started in low power mode");

    inta_space_a: assert property (@(negedge CLK_IN) disable iff (SRST_IN)
        (cycle_start && status_n == `BCC_STATUS_BOTH && !MEM_IO_SEL_IN && !compat_mode)
        |=> !inta_n)
        else $error("acknowledge not issued for I/O space code zero");

    // Clocked on both edges: the sampled clock is high only at falling edges,
    // so each check compares the outputs across the rising edge just passed
    falling_edge_a: assert property (@(CLK_IN) disable iff (SRST_IN)
        CLK_IN |-> $stable(mem_rd_n) && $stable(mem_wr_n) && $stable(io_rd_n)
        && $stable(io_wr_n) && $stable(inta_n) && $stable(data_en)
        && $stable(data_dir) && $stable(ale))
        else $error("output changed on a rising edge");

endmodule // bus_cmd_ctrl
`default_nettype wire

/* File: design/bus_cmd_pkg.sv */
// Types shared by the bus cycle command controller files
package bus_cmd_pkg;

    // Decoded kind of a bus cycle
    typedef enum logic [2:0] {
        CYC_IDLE,
        CYC_INTA,
        CYC_IORD,
        CYC_IOWR,
        CYC_HALT,
        CYC_MRD,
        CYC_MWR
    } cycle_kind_type;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_CMD
    } ctl_state_type;

endpackage

/* File: design/cycle_decoder.sv */
// Combinational decode of status pair and space select into a cycle kind
`timescale 1ns/1ps
`default_nettype none
`include "bus_cmd_cfg.svh"

module cycle_decoder
    import bus_cmd_pkg::*;
(
    input wire logic [1:0] status_n_in, // Status pair {bit1_n, bit0_n}
    input wire logic space_in, // High for memory, low for I/O
    output var cycle_kind_type kind_out // Decoded cycle kind
);

    // Lookup of the eight status and space combinations
    always_comb begin
        kind_out = CYC_IDLE;
        if (space_in == `BCC_SPACE_MEM) begin // Memory space
            unique case (status_n_in)
                `BCC_STATUS_BOTH: kind_out = CYC_HALT;
                `BCC_STATUS_READ: kind_out = CYC_MRD;
                `BCC_STATUS_WRITE: kind_out = CYC_MWR;
                `BCC_STATUS_IDLE: kind_out = CYC_IDLE;
            endcase
        end else begin // I/O space
            unique case (status_n_in)
                `BCC_STATUS_BOTH: kind_out = CYC_INTA;
                `BCC_STATUS_READ: kind_out = CYC_IORD;
                `BCC_STATUS_WRITE: kind_out = CYC_IOWR;
                `BCC_STATUS_IDLE: kind_out = CYC_IDLE;
            endcase
        end
    end

endmodule // cycle_decoder
`default_nettype wire

/* File: verif/cpu_core_model.sv */
// Processor core model that drives the cycle status pair and ready
`timescale 1ns/1ps
`default_nettype none

module cpu_core_model (
    input wire logic clk_in, // Controller clock
    input wire logic start_in, // Issue one cycle
    input wire logic [2:0] code_in, // {space, bit1_n, bit0_n}
    input wire logic [3:0] waits_in, // Wait states before ready
    input wire logic cmd_in, // High while a strobe is low
    output logic bit0_n_out, // Status bit 0, active low
    output logic bit1_n_out, // Status bit 1, active low
    output logic sel_out, // Memory/IO select
    output logic ready_n_out // Ready, active low
);
    logic [3:0] count; // Wait states left

    // Idle levels at time zero
    initial begin
        {sel_out, bit1_n_out, bit0_n_out} = 3'h7;
        ready_n_out = 1'h1;
        count = 4'h0;
    end

    // Changes half a period ahead of the sampling edge
    always @(posedge clk_in) begin
        if (start_in) begin
            {sel_out, bit1_n_out, bit0_n_out} <= code_in;
        end else begin
            {bit1_n_out, bit0_n_out} <= 2'h3;
        end
    end

    // Ready after the wait states, held until the strobe drops
    always @(posedge clk_in) begin
        if (!cmd_in) begin
            count <= waits_in;
            ready_n_out <= 1'h1;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
            ready_n_out <= 1'h1;
        end else begin
            ready_n_out <= 1'h0;
        end
    end
endmodule // cpu_core_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the bus cycle command controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic clk, srst, strap, low_power, start; // Bench drives
    logic [2:0] code; // Cycle code to issue
    logic [3:0] waits; // Wait states
    wire logic b0, b1, sel, rdy; // Core model outputs
    wire logic ale, mrd, mwr, ird, iwr, inta, den, ddir; // Design outputs
    wire logic [4:0] strobes; // All command strobes
    integer num_errors, checked; // Counters
    assign strobes = {mrd, mwr, ird, iwr, inta};

    bus_cmd_ctrl dut (.CLK_IN(clk), .SRST_IN(srst), .CYCLE_STATUS_BIT0_N_IN(b0),
        .CYCLE_STATUS_BIT1_N_IN(b1), .MEM_IO_SEL_IN(sel), .READY_N_IN(rdy),
        .MODE_STRAP_IN(strap), .LOW_POWER_IN(low_power), .ADDR_LATCH_OUT(ale),
        .MEM_RD_N_OUT(mrd), .MEM_WR_N_OUT(mwr), .IO_RD_N_OUT(ird), .IO_WR_N_OUT(iwr),
        .INTA_N_OUT(inta), .DATA_EN_OUT(den), .DATA_DIR_OUT(ddir));
    cpu_core_model core (.clk_in(clk), .start_in(start), .code_in(code), .waits_in(waits),
        .cmd_in(strobes != 5'h1F), .bit0_n_out(b0), .bit1_n_out(b1), .sel_out(sel),
        .ready_n_out(rdy));

    // 20 MHz clock
    always #25 clk = ~clk;

    // Expected strobes {mem rd, mem wr, io rd, io wr, inta} for a code
    function automatic logic [4:0] exp_strobes(input logic [2:0] c);
        case (c)
            3'h0: exp_strobes = 5'h1E;
            3'h1: exp_strobes = 5'h1B;
            3'h2: exp_strobes = 5'h1D;
            3'h5: exp_strobes = 5'h0F;
            3'h6: exp_strobes = 5'h17;
            default: exp_strobes = 5'h1F;
        endcase
    endfunction

    // Single-bit compare
    task automatic check_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %0b seen %0b", name, exp, got);
        end
    endtask

    // Strobe vector compare
    task automatic check_strobes(input logic [4:0] exp, input logic [4:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH strobes expected %h seen %h", exp, got);
        end
    endtask

    // Issue one cycle and follow it to its end
    task automatic run_cycle(input logic [2:0] c, input logic [3:0] w, input logic lp);
        logic go;
        logic [4:0] es;
        logic wr;
        go = (c[1:0] != 2'h3) && !lp;
        es = go ? exp_strobes(c) : 5'h1F;
        wr = (c[1:0] == 2'h2) && (es != 5'h1F);
        @(posedge clk);
        start <= 1'h1;
        code <= c;
        waits <= w;
        low_power <= lp;
        @(posedge clk);
        start <= 1'h0;
        @(posedge clk);
        check_bit("ale", go, ale);
        check_strobes(strap ? 5'h1F : es, strobes);
        check_bit("data_en", (es != 5'h1F) && (!strap || wr), den);
        check_bit("data_dir", wr, ddir);
        @(posedge clk);
        check_bit("ale_end", 1'h0, ale);
        check_strobes(es, strobes);
        for (int i = 0; i < 24 && strobes != 5'h1F; i++) begin
            @(posedge clk);
            if (strobes != 5'h1F) begin
                check_strobes(es, strobes);
            end
        end
        check_strobes(5'h1F, strobes);
        check_bit("data_en_off", 1'h0, den);
        low_power <= 1'h0;
    endtask

    // Print counts and verdict, then stop
    task automatic test_done();
        $display("Checks: %0d, errors: %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence: both timing modes, every code, then random traffic
    initial begin
        clk = 1'h0;
        srst = 1'h1;
        strap = 1'h0;
        low_power = 1'h0;
        start = 1'h0;
        code = 3'h7;
        waits = 4'h1;
        num_errors = 0;
        checked = 0;
        void'($urandom(63630));
        for (int m = 0; m < 2; m++) begin
            srst <= 1'h1;
            strap <= m[0];
            repeat (3) @(posedge clk);
            srst <= 1'h0;
            @(posedge clk);
            check_strobes(5'h1F, strobes);
            check_bit("ale_rst", 1'h0, ale);
            for (int c = 0; c < 8; c++) begin
                run_cycle(c[2:0], 4'h1, 1'h0);
            end
            run_cycle(3'h5, 4'h2, 1'h1);
            repeat (40) begin
                run_cycle(3'($urandom_range(7)), 4'($urandom_range(6, 1)),
                    $urandom_range(3) == 0);
            end
        end
        test_done();
    end

    // Watchdog against a hang
    initial begin
        #(50 * 4000);
        num_errors++;
        test_done();
    end
endmodule // tb_top
`default_nettype wire
